// ===== hdl/cbo_pkg.sv
// Constants, types and register map of the clock and buzzer output block
// Summary of operation
// [R1] Reset clears the output selection register: both outputs off, first dividers.
// [R2] Buzzer enable low stops its divider and holds the pin low; high drives it. The shared divider stops only with both outputs off.
// [R3] Buzzer field, bits 5 and 6, picks peripheral clock over 1024 to 8192.
// [R4] Clock output enable low stops its divider, pin low; high drives the clock. The shared divider stops only with both outputs off.
// [R5] Select field bits 0-3: peripheral clock over 2^n for 0-7, subsystem clock for 8.
// [R6] Software never picks a clock output above 10 MHz.
// [R7] At low supply on the internal oscillator, software avoids the undivided clock.
// [R8] Software changes the buzzer field only while the buzzer is disabled.
// [R9] Software changes the clock select field only while clock output is disabled.
// [R10] No short pulse on switching: start in a low phase, stop after a full high.
// [R11] Software programs the select field first, then sets bit 4.
// [R12] Software programs the buzzer field first, then sets bit 7.
// [R13] Reset sets the port direction register to all ones; bit 7 reads one.
// [R14] Direction bit 0 turns the pin driver on, 1 turns it off.
// [R15] Software clears direction and latch bits of pins 2 and 3 to route outputs.
// [R16] The selection register accepts single-bit and whole-byte processor writes.
// [R17] Each enable takes effect only while its divided clock is in a low phase.
package cbo_pkg;
   localparam logic [15:0] ADDR_PORT7_DIR = 16'hff27;
   localparam logic [15:0] ADDR_CLK_SEL = 16'hff40;
   localparam logic [15:0] ADDR_PORT7_LATCH = 16'hff07;
   localparam logic [7:0] RST_CLK_SEL = 8'h00;
   localparam logic [7:0] RST_PORT7_DIR = 8'hff;
   localparam logic [6:0] RST_PORT7_LATCH = 7'h00;
   localparam int CLK_SEL_LSB = 0;
   localparam int CLK_EN_BIT = 4;
   localparam int BUZ_SEL_LSB = 5;
   localparam int BUZ_EN_BIT = 7;
   localparam int DIR_FIXED_BIT = 7;
   localparam logic [3:0] CLK_SEL_LAST_DIV = 4'h7;
   localparam logic [3:0] CLK_SEL_SUB = 4'h8;
   // Peripheral clock runs at half of clock_i; divider bit n is fprs/2^n
   localparam int BUZ_DIV_BASE = 10;
   localparam int PRESC_W = 14;
   localparam int PIN_CLK = 2;
   localparam int PIN_BUZ = 3;
   localparam int PORT_W = 7;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic bit_wr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } cbo_bus_req_t;

   typedef struct packed {
      logic active;
      logic out;
   } cbo_gate_t;

   typedef struct packed {
      logic [7:0] clk_sel;
      logic [7:0] dir;
      logic [6:0] latch;
      logic [13:0] presc;
      logic [2:0] sub_sync;
      logic sub_lvl;
      logic [6:0] pin;
      logic [6:0] pin_oe;
      logic [7:0] rdata;
   } cbo_state_t;
endpackage

// ===== hdl/cbo_gate.sv
// Glitch-free enable gate for one divided clock
module cbo_gate (
   input wire logic clock_i,   // System clock
   input wire logic rstn_i,    // Async reset, active low
   input wire logic enable_i,  // Requested enable
   input wire logic src_i,     // Divided square wave
   output logic active_o,      // Gate open
   output logic out_o          // Gated wave
);
   import cbo_pkg::*;

   cbo_gate_t st;
   cbo_gate_t next_st;

   always_comb begin
      next_st = st;
      // [R17] enable follows low phase
      if (!src_i) begin
         next_st.active = enable_i;
      end
      // [R10] no clipped high phase
      next_st.out = next_st.active & src_i;
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign active_o = st.active;
   assign out_o = st.out;

   a_gate_start_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(st.active) |-> !st.out ##1 1) else $error("gate opened on a high phase"); // [R10]
   a_gate_stop_full: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $fell(st.out) |-> !$past(src_i)) else $error("gate closed mid high"); // [R10]
endmodule

// ===== hdl/cbo_top.sv
// Clock output and buzzer output controller with port 7 registers
module cbo_top (
   input wire logic clock_i,                  // System clock, twice peripheral rate
   input wire logic rstn_i,                   // Async reset, active low
   input wire cbo_pkg::cbo_bus_req_t bus_i,   // Processor memory access
   input wire logic sub_clk_i,                // Subsystem clock pin
   output logic [7:0] rdata_o,                // Read data, one cycle after rd
   output logic [6:0] pin_o,                  // Port 7 pin levels
   output logic [6:0] pin_oe_o                // Port 7 drivers on
);
   import cbo_pkg::*;

   cbo_state_t st;
   cbo_state_t next_st;
   logic clk_en;
   logic buz_en;
   logic [3:0] clk_code;
   logic [1:0] buz_code;
   logic clk_src;
   logic buz_src;
   logic clk_act;
   logic clk_out;
   logic buz_act;
   logic buz_out;
   logic run;
   logic [7:0] latch_wr;

   function automatic logic [7:0] apply_write(input logic [7:0] old, input cbo_bus_req_t req);
      logic [7:0] v;
      v = old;
      if (req.wr) begin
         v = req.wdata;
      end else if (req.bit_wr) begin
         v[req.bit_sel] = req.wdata[0];
      end
      return v;
   endfunction

   assign clk_en = st.clk_sel[CLK_EN_BIT];
   assign buz_en = st.clk_sel[BUZ_EN_BIT];
   assign clk_code = st.clk_sel[CLK_SEL_LSB +: 4];
   assign buz_code = st.clk_sel[BUZ_SEL_LSB +: 2];

   always_comb begin
      // [R5] clock output source select
      if (clk_code <= CLK_SEL_LAST_DIV) begin
         clk_src = st.presc[clk_code[2:0]];
      end else if (clk_code == CLK_SEL_SUB) begin
         clk_src = st.sub_lvl;
      end else begin
         clk_src = 1'b0;
      end
      // [R3] buzzer divide by 1024 to 8192
      buz_src = st.presc[BUZ_DIV_BASE + int'(buz_code)];
   end

   cbo_gate u_clk_gate (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .enable_i(clk_en),
      .src_i(clk_src),
      .active_o(clk_act),
      .out_o(clk_out)
   );

   cbo_gate u_buz_gate (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .enable_i(buz_en),
      .src_i(buz_src),
      .active_o(buz_act),
      .out_o(buz_out)
   );

   // Divider idles at zero so a restart always opens in a low phase
   assign run = clk_en | buz_en | clk_act | buz_act;

   always_comb begin
      next_st = st;
      // Latch is seven bits wide; bit 7 of the write is dropped
      latch_wr = apply_write({1'b0, st.latch}, bus_i);
      // [R2] divider runs only while needed
      if (run) begin
         next_st.presc = st.presc + 14'h0001;
      end else begin
         next_st.presc = '0;
      end
      // Three-stage sampling of the subsystem clock pin
      next_st.sub_sync = {st.sub_sync[1:0], sub_clk_i};
      if (st.sub_sync[1] == st.sub_sync[2]) begin
         next_st.sub_lvl = st.sub_sync[2];
      end
      // [R16] bit and byte writes
      if (bus_i.addr == ADDR_CLK_SEL) begin
         next_st.clk_sel = apply_write(st.clk_sel, bus_i);
      end
      if (bus_i.addr == ADDR_PORT7_DIR) begin
         next_st.dir = apply_write(st.dir, bus_i);
      end
      // [R13] top direction bit fixed
      next_st.dir[DIR_FIXED_BIT] = 1'b1;
      if (bus_i.addr == ADDR_PORT7_LATCH) begin
         next_st.latch = latch_wr[6:0];
      end
      // Reads of unmapped addresses return zero
      if (bus_i.rd) begin
         case (bus_i.addr)
            ADDR_CLK_SEL: next_st.rdata = st.clk_sel;
            ADDR_PORT7_DIR: next_st.rdata = st.dir;
            ADDR_PORT7_LATCH: next_st.rdata = {1'b0, st.latch};
            default: next_st.rdata = 8'h00;
         endcase
      end
      // [R14] driver on when direction bit is 0
      next_st.pin_oe = ~st.dir[6:0];
      // Function output ORs with the latch, so the latch must be cleared
      next_st.pin = st.latch;
      // [R4] gated clock onto its pin
      next_st.pin[PIN_CLK] = st.latch[PIN_CLK] | clk_out;
      // [R2] gated buzzer onto its pin
      next_st.pin[PIN_BUZ] = st.latch[PIN_BUZ] | buz_out;
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // [R1] [R13] reset values
         st <= '0;
         st.clk_sel <= RST_CLK_SEL;
         st.dir <= RST_PORT7_DIR;
         st.latch <= RST_PORT7_LATCH;
         st.pin_oe <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign pin_o = st.pin;
   assign pin_oe_o = st.pin_oe;

   a_sel_byte_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
      bus_i.wr && bus_i.addr == ADDR_CLK_SEL |=> st.clk_sel == $past(bus_i.wdata))
      else $error("byte write to select register lost"); // [R16]
   a_sel_bit_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !bus_i.wr && bus_i.bit_wr && bus_i.addr == ADDR_CLK_SEL
      |=> st.clk_sel[$past(bus_i.bit_sel)] == $past(bus_i.wdata[0]))
      else $error("bit write to select register lost"); // [R16]
   a_dir_top_one: assert property (@(posedge clock_i) disable iff (!rstn_i)
      st.dir[DIR_FIXED_BIT]) else $error("direction bit 7 not one"); // [R13]
   a_dir_drives_oe: assert property (@(posedge clock_i) disable iff (!rstn_i)
      ##1 pin_oe_o == ~$past(st.dir[6:0])) else $error("driver enable wrong"); // [R14]
   a_buz_idle_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !buz_act |-> !buz_out) else $error("buzzer high while off"); // [R2]
   a_clk_idle_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !clk_act |-> !clk_out) else $error("clock output high while off"); // [R4]
   a_presc_stopped: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !run |=> st.presc == '0) else $error("divider runs while off"); // [R2]
   a_buz_period: assert property (@(posedge clock_i) disable iff (!rstn_i)
      buz_act && buz_code == 2'b00 && $rose(buz_out) |-> ##1 buz_out [*8])
      else $error("buzzer high phase too short"); // [R3]
   a_clk_sub_path: assert property (@(posedge clock_i) disable iff (!rstn_i)
      clk_act && clk_code == CLK_SEL_SUB |=> clk_out == $past(st.sub_lvl))
      else $error("subsystem clock not routed"); // [R5]
   a_enable_delay: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $rose(clk_en) && run |-> ##[1:260] clk_act) else $error("clock output never opened"); // [R17]
   a_read_select: assert property (@(posedge clock_i) disable iff (!rstn_i)
      bus_i.rd && bus_i.addr == ADDR_CLK_SEL && !bus_i.wr && !bus_i.bit_wr
      |=> rdata_o == $past(st.clk_sel)) else $error("select read back wrong"); // [R16]

   a_clk_pin_route: assert property (@(posedge clock_i) disable iff (!rstn_i)
      1'b1 |=> pin_o[PIN_CLK] == $past(st.latch[PIN_CLK] | clk_out))
      else $error("clock output not on its pin"); // [R4]
   a_buz_pin_route: assert property (@(posedge clock_i) disable iff (!rstn_i)
      1'b1 |=> pin_o[PIN_BUZ] == $past(st.latch[PIN_BUZ] | buz_out))
      else $error("buzzer not on its pin"); // [R2]
   a_bad_code_low: assert property (@(posedge clock_i) disable iff (!rstn_i)
      clk_code > CLK_SEL_SUB |-> !clk_src) else $error("prohibited code drives clock"); // [R5]
   a_buz_stays_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !buz_en && !buz_act |=> !buz_act) else $error("buzzer gate opened unasked"); // [R2]

   c_buz_stop: cover property (@(posedge clock_i) disable iff (!rstn_i) $fell(buz_act));
   c_clk_running: cover property (@(posedge clock_i) disable iff (!rstn_i)
      clk_act && $rose(clk_out));
   c_buz_running: cover property (@(posedge clock_i) disable iff (!rstn_i)
      buz_act && $rose(buz_out));
   c_sub_selected: cover property (@(posedge clock_i) disable iff (!rstn_i)
      clk_act && clk_code == CLK_SEL_SUB && $rose(clk_out));
   c_clk_stop: cover property (@(posedge clock_i) disable iff (!rstn_i) $fell(clk_act));
endmodule

// ===== bench/cbo_partner.sv
// Far-side model: subsystem clock source and resolved pin levels
module cbo_partner #(
   parameter int SUB_HALF_NS = 100
) (
   input wire logic clock_i,          // System clock
   input wire logic [6:0] pin_i,      // Pin levels from the block
   input wire logic [6:0] pin_oe_i,   // Block drivers on
   output logic sub_clk_o,            // Subsystem clock
   output logic [6:0] lvl_o           // Level seen on each pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Crystal runs free; offset keeps its edges clear of clock_i edges
   initial begin
      sub_clk_o = 1'b0;
      #3;
      forever #(SUB_HALF_NS) sub_clk_o = ~sub_clk_o;
   end
   // Undriven pin toggles so a stale level never looks valid
   initial lvl_o = 7'h00;
   always @(posedge clock_i) begin
      for (int i = 0; i < 7; i++) lvl_o[i] <= pin_oe_i[i] ? pin_i[i] : ~lvl_o[i];
   end
endmodule

// ===== bench/cbo_top_tb.sv
// Self-checking bench of the clock and buzzer output block
module cbo_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cbo_pkg::*;
   logic clock_i;
   logic rstn_i;
   cbo_bus_req_t bus;
   logic sub_clk;
   logic [7:0] rdata;
   logic [6:0] pin;
   logic [6:0] pin_oe;
   logic [6:0] lvl;
   logic seen;
   int fails;
   int check_count;
   int n;
   cbo_top dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .bus_i(bus), .sub_clk_i(sub_clk),
      .rdata_o(rdata), .pin_o(pin), .pin_oe_o(pin_oe));
   cbo_partner part_u (.clock_i(clock_i), .pin_i(pin), .pin_oe_i(pin_oe),
      .sub_clk_o(sub_clk), .lvl_o(lvl));
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [15:0] a, input logic r, input logic w, input logic b,
      input logic [2:0] s, input logic [7:0] d);
      @(negedge clock_i);
      bus = '{addr: a, rd: r, wr: w, bit_wr: b, bit_sel: s, wdata: d};
      @(negedge clock_i);
      bus = '0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      acc(a, 1'b0, 1'b1, 1'b0, 3'h0, d);
   endtask
   task automatic bw(input logic [2:0] s, input logic v);
      acc(16'hff40, 1'b0, 1'b0, 1'b1, s, {7'h00, v});
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      acc(a, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00);
      chk(16'(rdata), 16'(exp));
   endtask
   // High width in cycles of the next pulse on a pin
   task automatic width(input int i, output int w);
      int k;
      w = 0;
      for (k = 0; k < 40000 && lvl[i] !== 1'b0; k++) @(negedge clock_i);
      for (k = 0; k < 40000 && lvl[i] !== 1'b1; k++) @(negedge clock_i);
      for (k = 0; k < 40000 && lvl[i] === 1'b1; k++) begin
         @(negedge clock_i);
         w++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clock_i);
      fails++;
      test_done();
   end
   initial begin
      bus = '0;
      rstn_i = 1'b0;
      fails = 0;
      check_count = 0;
      repeat (2) @(negedge clock_i);
      rstn_i = 1'b1;
      rd(16'hff40, 8'h00);
      rd(16'hff27, 8'hff);
      chk(16'(pin_oe), 16'h0000);
      chk(16'(pin), 16'h0000);
      $display("test reset done");
      wr(16'hff27, 8'h00);
      rd(16'hff27, 8'h80);
      chk(16'(pin_oe), 16'h007f);
      wr(16'hff27, 8'hf3);
      wr(16'hff07, 8'h41);
      repeat (2) @(negedge clock_i);
      chk(16'(pin_oe), 16'h000c);
      chk(16'(pin), 16'h0041);
      wr(16'hff07, 8'h00);
      rd(16'h1234, 8'h00);
      $display("test port done");
      // codes 0 and 1 exceed 10 MHz here
      for (int c = 2; c < 9; c++) begin
         wr(16'hff40, 8'(c));
         bw(3'h4, 1'b1);
         rd(16'hff40, 8'(c) | 8'h10);
         width(2, n);
         chk(16'(n), (c == 8) ? 16'h0005 : 16'(1 << c));
         bw(3'h4, 1'b0);
         repeat (300) @(negedge clock_i);
         chk(16'(pin[2]), 16'h0000);
      end
      wr(16'hff40, 8'h09);
      bw(3'h4, 1'b1);
      repeat (50) @(negedge clock_i);
      chk(16'(pin[2]), 16'h0000);
      $display("test clock codes done");
      bw(3'h4, 1'b0);
      wr(16'hff40, 8'h03);
      bw(3'h4, 1'b1);
      for (int k = 0; k < 400 && lvl[2] !== 1'b1; k++) @(negedge clock_i);
      bw(3'h4, 1'b0);
      n = 2;
      for (int k = 0; k < 400 && lvl[2] === 1'b1; k++) begin
         @(negedge clock_i);
         n++;
      end
      seen = 1'b0;
      repeat (100) begin
         @(negedge clock_i);
         seen = seen | pin[2];
      end
      chk(16'(n), 16'h0008);
      chk(16'(seen), 16'h0000);
      $display("test glitch free stop done");
      for (int b = 0; b < 4; b++) begin
         wr(16'hff40, {1'b0, 2'(b), 5'h00});
         bw(3'h7, 1'b1);
         width(3, n);
         chk(16'(n), 16'(1024 << b));
         bw(3'h7, 1'b0);
         repeat (20) @(negedge clock_i);
         chk(16'(pin[3]), 16'h0000);
      end
      $display("test buzzer done");
      test_done();
   end
endmodule
